// File: rtl/fsr_status_reset_mode.v
// status byte encoding, reset sources and interface mode selection
`timescale 1ns/100ps
`default_nettype none
`include "fsr_consts.vh"

// Notes on behaviour
// - control mark on data mark type mismatch
// - data field crc failure sets flag
// - header track differs sets wrong cylinder
// - mismatch plus ff track sets bad cylinder
// - no data mark found sets flag
// - status two bits 7,3,2 read zero
// - write protect pin shown in bit six
// - track zero pin shown in bit four
// - head and drive selects in low bits
// - bits five, three one; bit seven zero
// - pin, output reg, rate reg resets
// - any reset leaves power down
// - hardware reset aborts operations, goes idle
// - reset exit clears configure, enables polling
// - hardware reset spares specify timing values
// - pin reset clears output reg reset bit
// - both software resets reset core alike
// - rate reset self clears; output wins
// - mode from two-bit config field
// - first mode: dma bit gates, density high
// - second mode: always enabled, density low
// - third mode: dma bit gates, density low
// - density high after pin reset only
module fsr_status_reset_mode #(
    parameter [1:0] MODE_CODE_AT  = `FSR_MODE_CODE_AT,
    parameter [1:0] MODE_CODE_PS  = `FSR_MODE_CODE_PS,
    parameter [1:0] MODE_CODE_M30 = `FSR_MODE_CODE_M30
) (
    input  wire        core_clk,
    input  wire        reset,
    input  wire        hardware_reset_n,
    // register writes from the host side
    input  wire        dor_wr,
    input  wire [7:0]  dor_wdata,
    input  wire        dsr_wr,
    input  wire [7:0]  dsr_wdata,
    input  wire        cfg_wr,
    input  wire [7:0]  cfg_wdata,
    input  wire        specify_wr,
    input  wire [15:0] specify_wdata,
    input  wire        configure_wr,
    input  wire [7:0]  configure_wdata,
    input  wire        powerdown_req,
    input  wire        density_req,
    // result events from the data path
    input  wire        result_start,
    input  wire        read_deleted_cmd,
    input  wire        mark_seen,
    input  wire        mark_deleted,
    input  wire        mark_missing,
    input  wire        data_crc_fail,
    input  wire        header_valid,
    input  wire [7:0]  header_track,
    input  wire [7:0]  internal_track,
    input  wire        core_int_req,
    input  wire        core_dma_req,
    // drive pins
    input  wire        write_protect_in,
    input  wire        track_zero_in,
    input  wire        head_select_in,
    input  wire        drive_select_hi_in,
    input  wire        drive_select_lo_in,
    output reg  [7:0]  result_status_two,
    output reg  [7:0]  result_status_three,
    output reg  [7:0]  digital_output_reg,
    output reg  [7:0]  fdc_config_reg,
    output reg  [15:0] specify_timing,
    output reg  [7:0]  configure_info,
    output reg         polling_enable,
    output reg         core_reset,
    output reg         powered_down,
    output reg         idle,
    output reg         head_select_out,
    output reg         drive_select_hi,
    output reg         drive_select_lo,
    output reg         density_select,
    output reg         int_out,
    output reg         dma_req_out,
    output reg         mode_invalid
);

    localparam [2:0] MODE_AT  = 3'b001;
    localparam [2:0] MODE_PS  = 3'b010;
    localparam [2:0] MODE_M30 = 3'b100;

    reg        dsr_reset_reg;
    reg  [2:0] mode;
    reg        gate_en;
    reg        dens_high;
    reg        mode_reserved;
    wire       hw_rst;
    wire       dor_rst;
    wire       any_rst;
    wire       track_diff;

    assign hw_rst     = reset | ~hardware_reset_n;
    assign dor_rst    = ~digital_output_reg[`FSR_DOR_RESET_N_BIT];
    assign any_rst    = hw_rst | dor_rst | dsr_reset_reg;
    assign track_diff = header_valid & (header_track != internal_track);

    // mapping by parameter
    // reserved code falls back to the first mode
    always @* begin
        if (fdc_config_reg[`FSR_CFG_MODE_HI:`FSR_CFG_MODE_LO] == MODE_CODE_AT) begin
            mode          = MODE_AT;
            mode_reserved = 1'b0;
        end else if (fdc_config_reg[`FSR_CFG_MODE_HI:`FSR_CFG_MODE_LO] == MODE_CODE_PS) begin
            mode          = MODE_PS;
            mode_reserved = 1'b0;
        end else if (fdc_config_reg[`FSR_CFG_MODE_HI:`FSR_CFG_MODE_LO] == MODE_CODE_M30) begin
            mode          = MODE_M30;
            mode_reserved = 1'b0;
        end else begin
            mode          = MODE_AT;
            mode_reserved = 1'b1;
        end
    end

    always @* begin
        case (mode)
            MODE_AT: begin
                gate_en   = digital_output_reg[`FSR_DOR_DMA_EN_BIT];
                dens_high = 1'b1;
            end
            MODE_PS: begin
                gate_en   = 1'b1;
                dens_high = 1'b0;
            end
            MODE_M30: begin
                gate_en   = digital_output_reg[`FSR_DOR_DMA_EN_BIT];
                dens_high = 1'b0;
            end
            default: begin
                gate_en   = 1'b0;
                dens_high = 1'b1;
            end
        endcase
    end

    // host registers and reset sources
    // reset bit asserted
    always @(posedge core_clk) begin
        if (hw_rst) begin
            digital_output_reg <= `FSR_DOR_RESET_VAL;
        end else if (dor_wr) begin
            digital_output_reg <= dor_wdata;
        end
    end

    always @(posedge core_clk) begin
        if (hw_rst) begin
            fdc_config_reg <= `FSR_CFG_RESET_VAL;
        end else if (cfg_wr) begin
            fdc_config_reg <= cfg_wdata;
        end
    end

    // rate reset self clears; output reset wins
    always @(posedge core_clk) begin
        if (hw_rst) begin
            dsr_reset_reg <= 1'b0;
        end else begin
            dsr_reset_reg <= dsr_wr & dsr_wdata[`FSR_DSR_RESET_BIT] & ~dor_rst;
        end
    end

    // specify timing kept over resets
    // written values survive every reset source
    always @(posedge core_clk) begin
        if (specify_wr & ~any_rst) begin
            specify_timing <= specify_wdata;
        end
    end

    // status byte two flag events
    wire [7:0] st2_set;
    wire [7:0] result_status_two_next;

    assign st2_set[7] = 1'b0;
    assign st2_set[`FSR_ST2_CONTROL_MARK] = mark_seen & (mark_deleted ^ read_deleted_cmd);
    assign st2_set[`FSR_ST2_DATA_CRC_ERROR] = data_crc_fail;
    assign st2_set[`FSR_ST2_WRONG_CYLINDER] = track_diff;
    assign st2_set[3] = 1'b0;
    assign st2_set[2] = 1'b0;
    assign st2_set[`FSR_ST2_BAD_CYLINDER] = track_diff & (header_track == `FSR_BAD_TRACK);
    assign st2_set[`FSR_ST2_MISSING_DATA_MARK] = mark_missing;

    // flags sticky until result start
    // an event in the clear cycle still sets its flag
    genvar st2_bit;
    generate
        for (st2_bit = 0; st2_bit < 8; st2_bit = st2_bit + 1) begin : g_st2_flag
            assign result_status_two_next[st2_bit] = st2_set[st2_bit] |
                (result_status_two[st2_bit] & ~result_start);
        end
    endgenerate

    always @(posedge core_clk) begin
        if (any_rst) begin
            result_status_two <= 8'h00;
        end else begin
            result_status_two <= result_status_two_next;
        end
    end

    // three reset sources
    // lags the reset sources by one edge
    always @(posedge core_clk) begin
        core_reset <= any_rst;
    end

    always @(posedge core_clk) begin
        mode_invalid <= mode_reserved;
    end

    always @(posedge core_clk) begin
        if (any_rst) begin
            powered_down <= 1'b0;
        end else if (powerdown_req) begin
            powered_down <= 1'b1;
        end
    end

    always @(posedge core_clk) begin
        if (any_rst) begin
            idle <= 1'b1;
        end else begin
            idle <= ~core_int_req & ~core_dma_req;
        end
    end

    always @(posedge core_clk) begin
        if (any_rst) begin
            configure_info <= `FSR_CONFIG_RESET_VAL;
            polling_enable <= 1'b1;
        end else if (configure_wr) begin
            configure_info <= configure_wdata;
            polling_enable <= ~configure_wdata[`FSR_CONFIGURE_POLL_OFF_BIT];
        end
    end

    always @(posedge core_clk) begin
        if (any_rst) begin
            int_out <= 1'b0;
        end else begin
            int_out <= core_int_req & gate_en;
        end
    end

    always @(posedge core_clk) begin
        if (any_rst) begin
            dma_req_out <= 1'b0;
        end else begin
            dma_req_out <= core_dma_req & gate_en;
        end
    end

    // drive pins follow the core
    // held low while the core is in reset
    always @(posedge core_clk) begin
        if (any_rst) begin
            head_select_out <= 1'b0;
        end else begin
            head_select_out <= head_select_in;
        end
    end

    always @(posedge core_clk) begin
        if (any_rst) begin
            drive_select_hi <= 1'b0;
        end else begin
            drive_select_hi <= drive_select_hi_in;
        end
    end

    always @(posedge core_clk) begin
        if (any_rst) begin
            drive_select_lo <= 1'b0;
        end else begin
            drive_select_lo <= drive_select_lo_in;
        end
    end

    // density select polarity
    always @(posedge core_clk) begin
        if (hw_rst) begin
            density_select <= 1'b1;
        end else if (~dor_rst & ~dsr_reset_reg) begin
            // frozen while a software reset holds
            // active high in first mode
            density_select <= dens_high ? density_req : ~density_req;
        end
    end

    // status byte three snapshot
    wire [7:0] result_status_three_next;

    assign result_status_three_next[7] = 1'b0;
    assign result_status_three_next[`FSR_ST3_WRITE_PROTECT] = write_protect_in;
    assign result_status_three_next[`FSR_ST3_ONE_HI] = 1'b1;
    assign result_status_three_next[`FSR_ST3_TRACK_ZERO] = track_zero_in;
    assign result_status_three_next[`FSR_ST3_ONE_LO] = 1'b1;
    assign result_status_three_next[`FSR_ST3_HEAD] = head_select_out;
    assign result_status_three_next[1] = drive_select_hi;
    assign result_status_three_next[0] = drive_select_lo;

    always @(posedge core_clk) begin
        if (reset) begin
            result_status_three <= `FSR_ST3_RESET_VAL;
        end else begin
            result_status_three <= result_status_three_next;
        end
    end

endmodule // fsr_status_reset_mode
`default_nettype wire

// File: rtl/fsr_consts.vh
// constants for the floppy status, reset and mode block
`ifndef FSR_CONSTS_VH
`define FSR_CONSTS_VH

// status byte two fields
`define FSR_ST2_CONTROL_MARK      6
`define FSR_ST2_DATA_CRC_ERROR    5
`define FSR_ST2_WRONG_CYLINDER    4
`define FSR_ST2_BAD_CYLINDER      1
`define FSR_ST2_MISSING_DATA_MARK 0
// status byte three fields
`define FSR_ST3_WRITE_PROTECT     6
`define FSR_ST3_ONE_HI            5
`define FSR_ST3_TRACK_ZERO        4
`define FSR_ST3_ONE_LO            3
`define FSR_ST3_HEAD              2
`define FSR_ST3_RESET_VAL         8'h28
// configure word polling-disable bit
`define FSR_CONFIGURE_POLL_OFF_BIT 4
// hard-error track marker
`define FSR_BAD_TRACK             8'hFF
// output register field positions
`define FSR_DOR_RESET_N_BIT       2
`define FSR_DOR_DMA_EN_BIT        3
// rate-select reset bit position
`define FSR_DSR_RESET_BIT         7
// config register mode field
`define FSR_CFG_MODE_HI           3
`define FSR_CFG_MODE_LO           2
// reset values
`define FSR_DOR_RESET_VAL         8'h00
`define FSR_CFG_RESET_VAL         8'h00
`define FSR_CONFIG_RESET_VAL      8'h00
`define FSR_SPECIFY_RESET_VAL     16'h0000
// default mode field encodings
`define FSR_MODE_CODE_AT          2'h3
`define FSR_MODE_CODE_PS          2'h2
`define FSR_MODE_CODE_M30         2'h1

`endif

// File: sim/fsr_drive_model.sv
// drive-side model: the selected drive answers on the shared status pins
`timescale 1ns/100ps
`default_nettype none
module fsr_drive_model (
    input  wire logic       drive_select_hi,
    input  wire logic       drive_select_lo,
    input  wire logic [3:0] wp_map,
    input  wire logic [3:0] t0_map,
    output logic            write_protect_in,
    output logic            track_zero_in
);
    assign write_protect_in = wp_map[{drive_select_hi, drive_select_lo}];
    assign track_zero_in    = t0_map[{drive_select_hi, drive_select_lo}];
endmodule // fsr_drive_model
`default_nettype wire

// File: sim/fsr_status_reset_mode_assertions.sv
// concurrent checks on the status, reset and mode block ports
`timescale 1ns/100ps
`default_nettype none
module fsr_status_reset_mode_chk (
    input wire logic       core_clk,
    input wire logic       reset,
    input wire logic       hardware_reset_n,
    input wire logic       data_crc_fail,
    input wire logic       result_start,
    input wire logic       write_protect_in,
    input wire logic       track_zero_in,
    input wire logic       density_req,
    input wire logic       core_dma_req,
    input wire logic       dsr_wr,
    input wire logic [7:0] dsr_wdata,
    input wire logic [7:0] result_status_two,
    input wire logic [7:0] result_status_three,
    input wire logic [7:0] digital_output_reg,
    input wire logic [7:0] fdc_config_reg,
    input wire logic       core_reset,
    input wire logic       powered_down,
    input wire logic       density_select,
    input wire logic       int_out,
    input wire logic       dma_req_out
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset || !hardware_reset_n);
    chk_st2_unused: assert property (result_status_two[7] == 1'b0 && result_status_two[3:2] == 2'h0)
        else $error("status two unused bit set");
    chk_st3_const: assert property (!result_status_three[7] && result_status_three[5]
        && result_status_three[3])
        else $error("status three constant bits wrong");
    chk_wp_follow: assert property (($stable(write_protect_in) && !core_reset)[*3]
        |-> result_status_three[6] == write_protect_in) else $error("write protect not shown");
    chk_trk_follow: assert property (($stable(track_zero_in) && !core_reset)[*3]
        |-> result_status_three[4] == track_zero_in) else $error("track zero not shown");
    chk_crc_flag: assert property (data_crc_fail && !core_reset && !result_start
        |-> ##[1:3] result_status_two[5]) else $error("crc flag missing");
    chk_dsr_selfclr: assert property (dsr_wr && dsr_wdata[7] && digital_output_reg[2]
        && !core_reset |-> ##[1:3] core_reset ##[1:3] !core_reset) else $error("rate reset stuck");
    chk_pdn_exit: assert property ($rose(core_reset) |-> ##[0:1] !powered_down)
        else $error("power down kept in reset");
    chk_hw_dor: assert property ($rose(hardware_reset_n) |-> !digital_output_reg[2] && density_select)
        else $error("pin reset effects missing");
    chk_gate_off: assert property ((!core_reset && fdc_config_reg[3:2] != 2'h2
        && !digital_output_reg[3])[*3] |-> !dma_req_out && !int_out) else $error("gate leak");
    chk_ps_open: assert property ((!core_reset && fdc_config_reg[3:2] == 2'h2 && core_dma_req)[*3]
        |-> dma_req_out) else $error("dma blocked in second mode");
    chk_density_pol: assert property ((!core_reset && $stable(density_req)
        && $stable(fdc_config_reg))[*3]
        |-> density_select == ((fdc_config_reg[3:2] == 2'h2 || fdc_config_reg[3:2] == 2'h1)
        ? !density_req : density_req)) else $error("density polarity wrong");
    cov_dsr: cover property (dsr_wr && dsr_wdata[7] && !core_reset);
    cov_bad_cyl: cover property (result_status_two[1]);
    cov_ps_dma: cover property (fdc_config_reg[3:2] == 2'h2 && dma_req_out);
endmodule // fsr_status_reset_mode_chk
bind fsr_status_reset_mode fsr_status_reset_mode_chk chk_i (.core_clk, .reset, .hardware_reset_n,
    .data_crc_fail, .result_start, .write_protect_in, .track_zero_in, .density_req, .core_dma_req,
    .dsr_wr, .dsr_wdata, .result_status_two, .result_status_three, .digital_output_reg,
    .fdc_config_reg, .core_reset, .powered_down, .density_select, .int_out, .dma_req_out);
`default_nettype wire

// File: sim/testbench.sv
// self-checking bench for the status, reset and mode block
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic core_clk = 0, reset = 1, hardware_reset_n = 1, powerdown_req = 0, density_req = 0;
    logic dor_wr = 0, dsr_wr = 0, cfg_wr = 0, specify_wr = 0, configure_wr = 0;
    logic [7:0] dor_wdata = '0, dsr_wdata = '0, cfg_wdata = '0, configure_wdata = '0;
    logic [15:0] specify_wdata = '0, specify_timing;
    logic result_start = 0, read_deleted_cmd = 0, mark_seen = 0, mark_deleted = 0;
    logic mark_missing = 0, data_crc_fail = 0, header_valid = 0, core_int_req = 0;
    logic core_dma_req = 0, head_select_in = 0, drive_select_hi_in = 0, drive_select_lo_in = 0;
    logic [7:0] header_track = '0, internal_track = '0, result_status_two, result_status_three;
    logic [7:0] digital_output_reg, fdc_config_reg, configure_info;
    logic write_protect_in, track_zero_in, polling_enable, core_reset, powered_down, idle;
    logic head_select_out, drive_select_hi, drive_select_lo, density_select, int_out;
    logic dma_req_out, mode_invalid;
    logic [3:0] wp_map = 4'h5, t0_map = 4'h3;
    int err_total = 0, samples_checked = 0;
    fsr_status_reset_mode uut (.*);
    fsr_drive_model drv (.drive_select_hi, .drive_select_lo, .wp_map, .t0_map,
        .write_protect_in, .track_zero_in);
    always #5 core_clk = ~core_clk;
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    // k: 0 output reg, 1 rate select, 2 config, 3 specify, 4 configure
    task automatic wr(input int k, input logic [15:0] d);
        {dor_wdata, dsr_wdata, cfg_wdata, configure_wdata} = {4{d[7:0]}};
        specify_wdata = d;
        {dor_wr, dsr_wr, cfg_wr, specify_wr, configure_wr} = 5'h10 >> k;
        cyc(1);
        {dor_wr, dsr_wr, cfg_wr, specify_wr, configure_wr} = '0;
    endtask
    task automatic ev(input logic [4:0] e, input logic [7:0] ht, input logic [7:0] x);
        result_start = 1;
        cyc(1);
        result_start = 0;
        {read_deleted_cmd, mark_seen, mark_deleted, mark_missing, data_crc_fail} = e;
        {header_valid, header_track, internal_track} = {ht != 8'h00, ht, 8'h03};
        cyc(1);
        {read_deleted_cmd, mark_seen, mark_deleted, mark_missing, data_crc_fail} = '0;
        header_valid = 0;
        cyc(3);
        chk("status_two", {8'h00, x}, {8'h00, result_status_two});
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge core_clk);
        err_total++;
        report_and_stop;
    end
    initial begin
        cyc(16);
        reset = 0;
        cyc(2);
        chk("core_reset", 1, core_reset);
        chk("idle", 1, idle);
        chk("polling", 1, polling_enable);
        wr(0, 16'h0004);
        wr(4, 16'h0010);
        cyc(3);
        chk("core_reset", 0, core_reset);
        chk("polling", 0, polling_enable);
        $display("test reset_exit done");
        ev(5'h0C, 8'h00, 8'h40);
        ev(5'h18, 8'h00, 8'h40);
        ev(5'h1C, 8'h00, 8'h00);
        ev(5'h01, 8'h00, 8'h20);
        ev(5'h00, 8'h05, 8'h10);
        ev(5'h00, 8'hFF, 8'h12);
        ev(5'h00, 8'h03, 8'h00);
        ev(5'h02, 8'h00, 8'h01);
        $display("test status_two done");
        for (int d = 0; d < 4; d++) begin
            {drive_select_hi_in, drive_select_lo_in, head_select_in} = {d[1:0], d[0]};
            cyc(4);
            chk("status_three", {9'h000, wp_map[d], 1'b1, t0_map[d], 1'b1, d[0], d[1:0]},
                result_status_three);
            chk("drive_pins", {d[1:0], d[0]}, {drive_select_hi, drive_select_lo, head_select_out});
        end
        $display("test status_three done");
        {density_req, core_int_req, core_dma_req} = 3'h7;
        for (int m = 0; m < 4; m++) begin
            wr(2, {10'h000, m[1:0], 2'h0});
            wr(0, 16'h0004);
            cyc(3);
            chk("dma_req_out", m == 2, dma_req_out);
            chk("int_out", m == 2, int_out);
            chk("density", m == 0 || m == 3, density_select);
            chk("mode_invalid", m == 0, mode_invalid);
            chk("config", {m[1:0], 2'h0}, fdc_config_reg);
            wr(0, 16'h000C);
            cyc(3);
            chk("int_out", 1, int_out);
        end
        $display("test modes done");
        wr(3, 16'h1234);
        powerdown_req = 1;
        cyc(3);
        chk("powered_down", 1, powered_down);
        wr(1, 16'h0080);
        powerdown_req = 0;
        cyc(4);
        chk("core_reset", 0, core_reset);
        chk("configure", 0, configure_info);
        chk("powered_down", 0, powered_down);
        wr(0, 16'h0000);
        wr(1, 16'h0080);
        wr(3, 16'hBEEF);
        cyc(3);
        chk("core_reset", 1, core_reset);
        wr(0, 16'h0004);
        cyc(3);
        chk("core_reset", 0, core_reset);
        chk("specify", 16'h1234, specify_timing);
        $display("test soft_reset done");
        {density_req, hardware_reset_n} = 2'h0;
        cyc(2);
        hardware_reset_n = 1;
        chk("dor", 0, digital_output_reg);
        chk("density", 1, density_select);
        cyc(2);
        chk("core_reset", 1, core_reset);
        chk("specify", 16'h1234, specify_timing);
        $display("test hard_reset done");
        report_and_stop;
    end
endmodule // testbench
`default_nettype wire
